// [design/arb_pkg.sv]
// arb_pkg: offsets, field layouts and scaling limits for the adc result register bank.
// assumes byte-wide register reads from a serial management port engine.
package arb_pkg;

  localparam int unsigned ARB_NUM_CH = 7;
  localparam logic [7:0] ARB_OFF_IN1  = 8'h37;
  localparam logic [7:0] ARB_OFF_IN2  = 8'h39;
  localparam logic [7:0] ARB_OFF_BAT  = 8'h3b;
  localparam logic [7:0] ARB_OFF_SYS  = 8'h3d;
  localparam logic [7:0] ARB_OFF_THM  = 8'h3f;
  localparam logic [7:0] ARB_OFF_DIE  = 8'h41;
  localparam logic [7:0] ARB_OFF_DP   = 8'h43;
  localparam logic [7:0] ARB_OFF_LAST = 8'h44;
  localparam logic [15:0] ARB_RESULT_RST = 16'h0000;
  localparam logic [7:0]  ARB_BYTE_RST   = 8'h00;
  localparam logic [7:0]  ARB_UNMAPPED   = 8'h00;
  localparam logic [6:0]  ARB_OFF_RST    = 7'h00;

  // channel index order, also the bit order of the channel-off vector
  typedef enum logic [2:0] {
    ARB_CH_IN1 = 3'b000,
    ARB_CH_IN2 = 3'b001,
    ARB_CH_BAT = 3'b010,
    ARB_CH_SYS = 3'b011,
    ARB_CH_THM = 3'b100,
    ARB_CH_DIE = 3'b101,
    ARB_CH_DP  = 3'b110
  } arb_ch_e;

  // scaling: mv per lsb, full-scale codes (signed two's complement)
  localparam int ARB_MV_PER_LSB   = 1;
  localparam logic signed [15:0] ARB_IN_MAX   = 16'sd30000;
  localparam logic signed [15:0] ARB_BAT_MAX  = 16'sd20000;
  localparam logic signed [15:0] ARB_SYS_MAX  = 16'sd24000;
  localparam logic signed [15:0] ARB_THM_MAX  = 16'sd1023;
  localparam logic signed [15:0] ARB_DIE_MIN  = -16'sd80;
  localparam logic signed [15:0] ARB_DIE_MAX  = 16'sd300;
  localparam logic signed [15:0] ARB_ZERO     = 16'sd0;

  typedef struct packed {
    logic       valid;
    logic [2:0] chan;
    logic [15:0] code;
  } arb_conv_s;

  typedef struct packed {
    logic       rd;
    logic [7:0] addr;
  } arb_rdreq_s;

endpackage : arb_pkg

// [design/arb_result_slot.sv]
// arb_result_slot: one 16-bit result register with range clamp and channel-off gate.
// assumes conversion strobes are synchronous to clk.
`timescale 1ns/1ps
module arb_result_slot
  import arb_pkg::*;
#(
  parameter logic signed [15:0] LO = 16'sd0,
  parameter logic signed [15:0] HI = 16'sd0
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        load,
  input  wire logic        chan_off,
  input  wire logic [15:0] code,
  output logic      [15:0] result_q
);

  logic signed [15:0] code_s;
  logic        [15:0] result_d;

  assign code_s = code;

  // clamp keeps reported codes inside the documented span, in two's complement
  always_comb begin
    if (code_s < LO) begin
      result_d = LO;
    end else if (code_s > HI) begin
      result_d = HI;
    end else begin
      result_d = code;
    end
  end

  // a disabled channel holds its last value rather than zeroing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= ARB_RESULT_RST;
    end else if (ce && load && !chan_off) begin
      result_q <= result_d;
    end
  end

endmodule : arb_result_slot

// [design/arb_result_bank.sv]
// arb_result_bank: read-only adc result registers behind the serial management port.
// assumes the port engine issues one byte read per rd strobe and holds addr stable for it.
`timescale 1ns/1ps
module arb_result_bank
  import arb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        reg_reset,
  input  wire logic [6:0]  channel_off,
  input  wire arb_conv_s   conv,
  input  wire arb_rdreq_s  rdreq,
  output logic [7:0]       rd_data_q,
  output logic             rd_valid_q,
  output logic [6:0]       channel_off_q,
  output logic [6:0]       result_fresh_q
);

  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic [6:0]  channel_off_d;
  logic [15:0] result [ARB_NUM_CH];
  logic [6:0]  load_hit;
  logic [6:0]  high_hit;
  logic [6:0]  fresh_d;
  logic        rd_hit;
  logic        rd_high;
  logic [2:0]  rd_chan;
  logic [15:0] rd_word;
  logic [15:0] snap_q;
  logic [15:0] snap_d;
  logic [7:0]  rd_data_d;
  logic        rd_valid_d;

  // async assert, synchronous release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // channel-off controls; register reset wins over a request in the same cycle
  always_comb begin
    if (reg_reset) begin
      channel_off_d = ARB_OFF_RST;
    end else begin
      channel_off_d = channel_off;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_off_q <= ARB_OFF_RST;
    end else if (ce) begin
      channel_off_q <= channel_off_d;
    end
  end

  // only the die temperature may read below zero
  function automatic logic signed [15:0] ch_lo(input int i);
    case (i)
      ARB_CH_DIE: ch_lo = ARB_DIE_MIN;
      default:    ch_lo = ARB_ZERO;
    endcase
  endfunction : ch_lo

  function automatic logic signed [15:0] ch_hi(input int i);
    case (i)
      ARB_CH_IN1, ARB_CH_IN2: ch_hi = ARB_IN_MAX;
      ARB_CH_BAT:             ch_hi = ARB_BAT_MAX;
      ARB_CH_SYS:             ch_hi = ARB_SYS_MAX;
      ARB_CH_THM:             ch_hi = ARB_THM_MAX;
      ARB_CH_DIE:             ch_hi = ARB_DIE_MAX;
      default:                ch_hi = 16'sh7fff;
    endcase
  endfunction : ch_hi

  // per-channel strobes; a disabled channel neither loads nor reports fresh data
  for (genvar h = 0; h < ARB_NUM_CH; h++) begin : g_hit
    assign load_hit[h] = conv.valid && (conv.chan == 3'(h)) && !channel_off_q[h];
    assign high_hit[h] = rdreq.rd && (rdreq.addr == ARB_OFF_IN1 + 8'(2 * h));
    // set wins over a clear in the same cycle, so a new result is never reported stale
    assign fresh_d[h]  = load_hit[h] || (result_fresh_q[h] && !high_hit[h]);
  end

  // one slot per channel; signed clamp carries the two's-complement coding
  for (genvar g = 0; g < ARB_NUM_CH; g++) begin : g_slot
    arb_result_slot #(
      .LO (ch_lo(g)),
      .HI (ch_hi(g))
    ) u_slot (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .load     (conv.valid && (conv.chan == 3'(g))),
      .chan_off (channel_off_q[g]),
      .code     (conv.code),
      .result_q (result[g])
    );
  end

  // sticky per-channel flag: set on a load, cleared when the high byte is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_fresh_q <= 7'h00;
    end else if (ce) begin
      result_fresh_q <= fresh_d;
    end
  end

  function automatic logic in_bank(input logic [7:0] a);
    in_bank = (a >= ARB_OFF_IN1) && (a <= ARB_OFF_LAST);
  endfunction : in_bank

  function automatic logic [2:0] ch_of(input logic [7:0] a);
    logic [7:0] rel;
    rel   = a - ARB_OFF_IN1;
    ch_of = rel[3:1];
  endfunction : ch_of

  function automatic logic is_high(input logic [7:0] a);
    logic [7:0] rel;
    rel     = a - ARB_OFF_IN1;
    is_high = ~rel[0];
  endfunction : is_high

  // one address decode feeds both the snapshot and the byte mux
  always_comb begin
    rd_hit  = in_bank(rdreq.addr);
    rd_high = is_high(rdreq.addr);
    rd_chan = ch_of(rdreq.addr);
    rd_word = ARB_RESULT_RST;
    if (rd_hit) begin
      rd_word = result[rd_chan];
    end
  end

  // the high byte snapshots the whole word; a conversion between the two reads cannot tear it
  always_comb begin
    snap_d = snap_q;
    if (rdreq.rd && rd_hit && rd_high) begin
      snap_d = rd_word;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_q <= ARB_RESULT_RST;
    end else if (ce) begin
      snap_q <= snap_d;
    end
  end

  // high byte from the live word, low byte from the snapshot; unmapped reads zero
  always_comb begin
    rd_valid_d = rdreq.rd;
    rd_data_d  = rd_data_q;
    if (rdreq.rd) begin
      if (!rd_hit) begin
        rd_data_d = ARB_UNMAPPED;
      end else if (rd_high) begin
        rd_data_d = rd_word[15:8];
      end else begin
        rd_data_d = snap_q[7:0];
      end
    end
  end

  // answer strobe, one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_q <= 1'b0;
    end else if (ce) begin
      rd_valid_q <= rd_valid_d;
    end
  end

  // read byte holds until the next read, so a slow host can still pick it up
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= ARB_BYTE_RST;
    end else if (ce) begin
      rd_data_q <= rd_data_d;
    end
  end

endmodule : arb_result_bank

// [sim/arb_result_bank_properties.sv]
// arb_result_bank_properties: port checker for the result bank.
// assumes it is bound to every arb_result_bank; one clock domain.
`timescale 1ns/1ps
module arb_chk
  import arb_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic reg_reset,
  input wire logic [6:0] channel_off,
  input wire arb_conv_s conv,
  input wire arb_rdreq_s rdreq,
  input wire logic [7:0] rd_data_q,
  input wire logic rd_valid_q,
  input wire logic [6:0] channel_off_q,
  input wire logic [6:0] result_fresh_q
);
  logic [1:0] up_q;
  // the bank leaves reset two edges after resetn, so checks wait one edge more
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn || up_q != 2'h3);
  wire rq = ce && rdreq.rd;
  property p_rv; rq |=> rd_valid_q; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_nrv; ce && !rdreq.rd |=> !rd_valid_q; endproperty
  a_nrv: assert property (p_nrv) else $error("stray answer");
  property p_hold; !rq |=> $stable(rd_data_q); endproperty
  a_hold: assert property (p_hold) else $error("byte moved");
  property p_unm; rq && rdreq.addr > ARB_OFF_LAST |=> rd_data_q == ARB_UNMAPPED; endproperty
  a_unm: assert property (p_unm) else $error("unmapped not zero");
  property p_off; ce && !reg_reset |=> channel_off_q == $past(channel_off); endproperty
  a_off: assert property (p_off) else $error("off copy wrong");
  property p_rr; ce && reg_reset |=> channel_off_q == 7'h00; endproperty
  a_rr: assert property (p_rr) else $error("off not cleared");
  property p_frz; !ce |=> $stable(channel_off_q) && $stable(result_fresh_q) && $stable(rd_valid_q); endproperty
  a_frz: assert property (p_frz) else $error("state moved, ce low");
  property p_new;
    ce && conv.valid && channel_off_q == 7'h00 && channel_off == 7'h00 |=> result_fresh_q[$past(conv.chan)];
  endproperty
  a_new: assert property (p_new) else $error("conversion lost");
  c_rd: cover property (rq ##1 rq);
  c_cv: cover property (ce && conv.valid);
  c_rr: cover property (ce && reg_reset);
endmodule : arb_chk
bind arb_result_bank arb_chk i_arb_chk (.clk(clk), .resetn(resetn), .ce(ce), .reg_reset(reg_reset),
  .channel_off(channel_off), .conv(conv), .rdreq(rdreq), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
  .channel_off_q(channel_off_q), .result_fresh_q(result_fresh_q));

// [sim/arb_host_model.sv]
// arb_host_model: serial host stand-in issuing byte reads, catching answers.
// assumes go is a one-cycle request driven just after a clock edge.
`timescale 1ns/1ps
module arb_host_model
  import arb_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] a,
  output arb_rdreq_s rq,
  input wire logic rv,
  input wire logic [7:0] rd,
  output logic [7:0] d
);
  // idle address shows its inverse, so a stale decode cannot pass
  assign rq = '{go, go ? a : ~a};
  always_ff @(posedge clk) if (rv) d <= rd;
endmodule : arb_host_model

// [sim/tb_arb_result_bank.sv]
// tb_arb_result_bank: directed reads and conversions against the result bank.
// assumes the host model and checker are compiled alongside.
`timescale 1ns/1ps
module tb_arb_result_bank;
  import arb_pkg::*;
  logic clk = 0, resetn = 0, ce = 1, reg_reset = 0, go = 0, rv;
  logic [6:0] channel_off = 0, off_q, fresh_q;
  logic [7:0] a = 0, rdd, d, b;
  logic [15:0] w;
  logic [15:0] codes [7] = '{16'd30000, 16'd1, 16'd20000, 16'd24000, 16'd1023, 16'hffb0, 16'h0e10};
  arb_conv_s conv = '0;
  arb_rdreq_s rq;
  int fails = 0, comparisons = 0, cyc = 0;
  initial forever #25 clk = ~clk;
  arb_result_bank i_arb_result_bank (.clk(clk), .resetn(resetn), .ce(ce), .reg_reset(reg_reset),
    .channel_off(channel_off), .conv(conv), .rdreq(rq), .rd_data_q(rdd), .rd_valid_q(rv),
    .channel_off_q(off_q), .result_fresh_q(fresh_q));
  arb_host_model i_arb_host_model (.clk(clk), .go(go), .a(a), .rq(rq), .rv(rv), .rd(rdd), .d(d));
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rd8(logic [7:0] o, output logic [7:0] v);
    @(posedge clk) begin go <= 1; a <= o; end
    @(posedge clk) go <= 0;
    @(posedge clk) #1 v = d;
  endtask : rd8
  // high byte first: it snapshots the word for the low byte
  task automatic rd16(logic [7:0] o, output logic [15:0] v);
    rd8(o, v[15:8]);
    rd8(o + 8'h01, v[7:0]);
  endtask : rd16
  task automatic cr(arb_ch_e c, logic [15:0] code, logic [15:0] e);
    @(posedge clk) conv <= '{1'b1, c, code};
    @(posedge clk) conv.valid <= 1'b0;
    #1 chk("fresh set", fresh_q[c], !channel_off[c]);
    rd16(ARB_OFF_IN1 + {4'h0, c, 1'b0}, w);
    chk("result", w, e);
    chk("fresh clear", fresh_q[c], 0);
  endtask : cr
  task automatic chk_zero();
    for (int i = 0; i < 7; i++) begin
      rd16(ARB_OFF_IN1 + 8'(2 * i), w);
      chk("reset", w, 16'h0000);
    end
  endtask : chk_zero
  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  always @(posedge clk) if (++cyc > 3000) begin fails++; complete_run(); end
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1;
    repeat (3) @(posedge clk);
    chk_zero();
    for (int i = 0; i < 7; i++) cr(arb_ch_e'(i), codes[i], codes[i]);
    cr(ARB_CH_IN1, 16'hffff, 16'h0000);
    cr(ARB_CH_SYS, 16'd24001, 16'd24000);
    cr(ARB_CH_DIE, 16'hffaf, 16'hffb0);
    @(posedge clk) channel_off <= 7'h04;
    @(posedge clk) #1 chk("off copy", off_q, 7'h04);
    cr(ARB_CH_BAT, 16'd5, 16'd20000);
    chk("fresh", fresh_q[2], 0);
    @(posedge clk) reg_reset <= 1;
    @(posedge clk) begin reg_reset <= 0; channel_off <= 0; end
    #1 chk("off cleared", off_q, 0);
    cr(ARB_CH_BAT, 16'h0102, 16'h0102);
    rd8(ARB_OFF_BAT, b);
    cr(ARB_CH_BAT, 16'h0304, 16'h0304);
    rd8(ARB_OFF_BAT, b);
    @(posedge clk) conv <= '{1'b1, ARB_CH_BAT, 16'h0506};
    @(posedge clk) conv.valid <= 1'b0;
    rd8(ARB_OFF_BAT + 8'h01, b);
    chk("snapshot low", b, 8'h04);
    @(posedge clk) begin ce <= 0; conv <= '{1'b1, ARB_CH_DP, 16'h0001}; go <= 1; a <= ARB_OFF_DP; end
    @(posedge clk) begin conv.valid <= 1'b0; go <= 0; end
    #1 chk("frozen answer", rv, 0);
    chk("frozen fresh", fresh_q[ARB_CH_DP], 0);
    @(posedge clk) ce <= 1;
    rd16(ARB_OFF_DP, w);
    chk("frozen", w, 16'h0e10);
    rd8(8'h45, b);
    chk("unmapped", b, 0);
    @(posedge clk) resetn <= 0;
    repeat (2) @(posedge clk);
    #1 chk("reset fresh", fresh_q, 0);
    chk("reset off", off_q, 0);
    @(posedge clk) resetn <= 1;
    repeat (3) @(posedge clk);
    chk_zero();
    complete_run();
  end
endmodule : tb_arb_result_bank
